// >>> smcg_ctrl.sv
// Purpose: sleep mode sequencing, clock domain gating and peripheral clock gating
// Assumes: wake inputs come from logic on the same clock; resets handled elsewhere
// Notes: resets wake the chip by resetting this block, so they are not wake inputs here
`timescale 1ns/1ps
module smcg_ctrl (
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic sleep_exec,
  input wire logic global_irq_en,
  input wire logic [1:0] timer2_irq_mask,
  // fuses and peripheral status
  input wire logic [15:0] startup_cycles,
  input wire logic crystal_clock,
  input wire logic debug_enable_fuse,
  input wire logic test_port_enable_fuse,
  input wire logic brownout_fuse_en,
  input wire logic watchdog_en,
  input wire logic adc_enabled,
  input wire logic timer2_enabled,
  input wire logic timer2_async,
  input wire smcg_pkg::smcg_wake_t wake,
  // outputs
  output smcg_pkg::smcg_clocks_t clocks,
  output smcg_pkg::smcg_periph_t periph_clk_en,
  output smcg_pkg::smcg_periph_t periph_access_en,
  output logic adc_start,
  output logic adc_extended,
  output logic comparator_en,
  output logic reference_en,
  output logic brownout_en,
  output logic watchdog_run,
  output logic input_buffer_en,
  output logic test_port_en,
  output logic cpu_resume,
  output logic asleep
);
  typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_STARTUP, ST_HALT} smcg_state_t;

  logic [3:0] sleep_control_reg; // mode in bits 3..1, enable in bit 0
  logic [3:0] power_reduction_reg; // gate bits, upper bits read zero
  logic [1:0] comparator_ctrl_status_reg; // disable and bandgap select
  logic test_port_disable_bit;
  smcg_state_t state;
  logic [2:0] mode; // mode latched at entry
  logic [15:0] wait_count;
  logic irq_wake; // wake came from an interrupt
  logic adc_was_on; // for extended conversion tracking
  logic next_wake;
  logic [2:0] sel;
  logic sel_legal;
  logic acc;
  logic wr;

  assign sel = sleep_control_reg[3:1];
  // reserved codes never enter sleep
  assign sel_legal = (sel == smcg_pkg::MODE_IDLE) || (sel == smcg_pkg::MODE_ADC_NR) ||
    (sel == smcg_pkg::MODE_POWER_DOWN) || (sel == smcg_pkg::MODE_POWER_SAVE) ||
    (sel == smcg_pkg::MODE_STANDBY && crystal_clock);
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // zero wait slave, unmapped reads zero with error
  assign pready = 1'b1;

  // wake decode per mode
  function automatic logic wake_for(input logic [2:0] m, input smcg_pkg::smcg_wake_t w,
                                    input logic t2_ok);
    logic deep;
    deep = w.usi_start || w.ext0_level || w.pin_change;
    unique case (m)
      smcg_pkg::MODE_IDLE: wake_for = w.any_irq;
      smcg_pkg::MODE_ADC_NR: wake_for = deep || w.adc_done || w.store_ready ||
        ((w.timer2_ovf || w.timer2_cmp) && t2_ok);
      smcg_pkg::MODE_POWER_SAVE: wake_for = deep ||
        ((w.timer2_ovf && timer2_irq_mask[0]) ||
         (w.timer2_cmp && timer2_irq_mask[1])) && global_irq_en;
      default: wake_for = deep; // power-down and standby
    endcase
  endfunction : wake_for

  assign next_wake = (state == ST_SLEEP) &&
    wake_for(mode, wake, global_irq_en && (timer2_irq_mask != 2'h0));

  // register writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_control_reg <= smcg_pkg::SLEEP_CONTROL_RST;
      power_reduction_reg <= smcg_pkg::POWER_REDUCTION_RST;
      comparator_ctrl_status_reg <= smcg_pkg::COMPARATOR_CTRL_RST;
      test_port_disable_bit <= smcg_pkg::TEST_PORT_DISABLE_RST;
    end else if (wr) begin
      unique case (paddr)
        smcg_pkg::SLEEP_CONTROL_OFS: sleep_control_reg <= pwdata[3:0];
        smcg_pkg::POWER_REDUCTION_OFS: power_reduction_reg <= pwdata[3:0];
        smcg_pkg::COMPARATOR_CTRL_OFS: begin
          comparator_ctrl_status_reg <= {pwdata[smcg_pkg::COMPARATOR_DISABLE_POS],
                                         pwdata[smcg_pkg::COMPARATOR_BANDGAP_POS]};
        end
        smcg_pkg::MCU_CTRL_OFS: begin
          test_port_disable_bit <= pwdata[smcg_pkg::TEST_PORT_DISABLE_POS];
        end
        default: begin
          // status and unmapped: nothing stored
        end
      endcase
    end
  end

  // read data from flip-flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        smcg_pkg::SLEEP_CONTROL_OFS: prdata <= {28'h0, sleep_control_reg};
        smcg_pkg::POWER_REDUCTION_OFS: prdata <= {28'h0, power_reduction_reg};
        smcg_pkg::COMPARATOR_CTRL_OFS: prdata <= {24'h0, comparator_ctrl_status_reg, 6'h0};
        smcg_pkg::MCU_CTRL_OFS: prdata <= {24'h0, test_port_disable_bit, 7'h0};
        smcg_pkg::STATUS_OFS: prdata <= {27'h0, irq_wake, mode, asleep};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // error on unmapped address, and on writes to status
  assign pslverr = acc && (paddr > smcg_pkg::STATUS_OFS || paddr[1:0] != 2'h0 ||
                           (pwrite && paddr == smcg_pkg::STATUS_OFS));

  // sleep sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_ACTIVE;
      mode <= smcg_pkg::MODE_IDLE;
      wait_count <= 16'h0;
      irq_wake <= 1'b0;
    end else begin
      unique case (state)
        ST_ACTIVE: begin
          // sleep enable gates the instruction
          if (sleep_exec && sleep_control_reg[smcg_pkg::SLEEP_ENABLE_POS] && sel_legal) begin
            state <= ST_SLEEP;
            mode <= sel;
          end
        end
        ST_SLEEP: begin
          if (next_wake) begin
            irq_wake <= 1'b1;
            state <= ST_STARTUP;
            // oscillator restart only where it was stopped
            if (mode == smcg_pkg::MODE_POWER_DOWN || mode == smcg_pkg::MODE_POWER_SAVE)
              wait_count <= startup_cycles;
            else if (mode == smcg_pkg::MODE_STANDBY)
              wait_count <= 16'(smcg_pkg::STANDBY_WAKE_CYCLES - 1);
            else
              wait_count <= 16'h0;
          end
        end
        ST_STARTUP: begin
          // clocks held off until count runs out, so restart is glitch free
          if (wait_count == 16'h0) begin
            state <= ST_HALT;
            wait_count <= 16'(smcg_pkg::IRQ_HALT_CYCLES - 1);
          end else begin
            wait_count <= wait_count - 16'h1;
          end
        end
        ST_HALT: begin
          if (wait_count == 16'h0) begin
            state <= ST_ACTIVE;
            irq_wake <= 1'b0;
          end else begin
            wait_count <= wait_count - 16'h1;
          end
        end
        default: state <= ST_ACTIVE;
      endcase
    end
  end

  // adc restart tracking for extended conversion
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      adc_was_on <= 1'b0;
      adc_extended <= 1'b1;
      adc_start <= 1'b0;
    end else begin
      adc_was_on <= adc_enabled;
      if (adc_enabled && !adc_was_on) adc_extended <= 1'b1;
      else if (adc_start) adc_extended <= 1'b0;
      // conversion kicked off on entry to idle or noise reduction
      adc_start <= (state == ST_ACTIVE) && sleep_exec && adc_enabled && sel_legal &&
        sleep_control_reg[smcg_pkg::SLEEP_ENABLE_POS] &&
        (sel == smcg_pkg::MODE_IDLE || sel == smcg_pkg::MODE_ADC_NR);
    end
  end

  // clock domain gating, held off through start-up
  always_comb begin
    logic sleeping;
    logic deep;
    logic osc_hold;
    sleeping = (state == ST_SLEEP) || (state == ST_STARTUP);
    deep = (mode == smcg_pkg::MODE_POWER_DOWN) || (mode == smcg_pkg::MODE_POWER_SAVE) ||
      (mode == smcg_pkg::MODE_STANDBY);
    osc_hold = debug_enable_fuse && (mode == smcg_pkg::MODE_POWER_DOWN ||
      mode == smcg_pkg::MODE_POWER_SAVE);
    clocks.cpu = (state == ST_ACTIVE);
    clocks.flash = (state == ST_ACTIVE);
    clocks.io = !sleeping || (mode == smcg_pkg::MODE_IDLE);
    clocks.adc = !sleeping || !deep;
    clocks.asy = !sleeping || !deep ||
      (mode == smcg_pkg::MODE_POWER_SAVE && timer2_enabled);
    clocks.main_osc = !sleeping || !deep || (mode == smcg_pkg::MODE_STANDBY) || osc_hold ||
      (mode == smcg_pkg::MODE_POWER_SAVE && timer2_enabled && !timer2_async);
    clocks.timer_osc = timer2_async && (!sleeping || !deep ||
      (mode == smcg_pkg::MODE_POWER_SAVE && timer2_enabled));
    if (state == ST_STARTUP && deep) begin
      clocks.io = 1'b0;
      clocks.adc = 1'b0;
    end
  end

  assign asleep = (state != ST_ACTIVE);

  // per-peripheral gating follows io and adc clocks so deep sleep overrides
  assign periph_clk_en.timer16 = !power_reduction_reg[3] && clocks.io;
  assign periph_clk_en.spi = !power_reduction_reg[2] && clocks.io;
  assign periph_clk_en.usart = !power_reduction_reg[1] && clocks.io;
  assign periph_clk_en.adc = !power_reduction_reg[0] && clocks.adc;
  assign periph_access_en = smcg_pkg::smcg_periph_t'(~power_reduction_reg);

  // comparator and reference; adc left enabled by its own bit in any mode
  assign comparator_en = !comparator_ctrl_status_reg[1] &&
    (!asleep || !(mode == smcg_pkg::MODE_POWER_DOWN || mode == smcg_pkg::MODE_POWER_SAVE ||
      mode == smcg_pkg::MODE_STANDBY) || comparator_ctrl_status_reg[0]);
  assign reference_en = brownout_fuse_en || adc_enabled ||
    (comparator_en && comparator_ctrl_status_reg[0]);
  assign brownout_en = brownout_fuse_en;
  assign watchdog_run = watchdog_en;
  assign input_buffer_en = clocks.io || clocks.adc;
  assign test_port_en = test_port_enable_fuse && !test_port_disable_bit;
  assign cpu_resume = (state == ST_HALT) && (wait_count == 16'h0);

  a_idle_clocks: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_SLEEP && mode == smcg_pkg::MODE_IDLE) |-> !clocks.cpu && clocks.io)
    else $error("idle clocks wrong");
  a_nr_io_off: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_SLEEP && mode == smcg_pkg::MODE_ADC_NR) |-> !clocks.io && clocks.adc)
    else $error("noise reduction clocks wrong");
  a_pd_all_off: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_SLEEP && mode == smcg_pkg::MODE_POWER_DOWN && !debug_enable_fuse)
    |-> !clocks.main_osc && !clocks.asy && !clocks.adc)
    else $error("power-down clocks running");
  a_se_gate: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_ACTIVE && sleep_exec && !sleep_control_reg[0]) |=> state == ST_ACTIVE)
    else $error("slept without enable");
  a_reserved_mode: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_ACTIVE && !sel_legal) |=> state == ST_ACTIVE)
    else $error("reserved mode entered");
  a_halt_four: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_STARTUP && wait_count == 16'h0) |=> (state == ST_HALT) [*4] ##1
    state == ST_ACTIVE)
    else $error("halt not four cycles");
  a_standby_wake: assert property (@(posedge clock) disable iff (!rst_b)
    (next_wake && mode == smcg_pkg::MODE_STANDBY) |-> ##7 state == ST_HALT)
    else $error("standby wake not six cycles");
  a_gate_stops: assert property (@(posedge clock) disable iff (!rst_b)
    power_reduction_reg[2] |-> !periph_clk_en.spi && !periph_access_en.spi)
    else $error("gated spi clock running");
  a_psave_t2: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_SLEEP && mode == smcg_pkg::MODE_POWER_SAVE && !global_irq_en &&
     !wake.usi_start && !wake.ext0_level && !wake.pin_change) |=> state == ST_SLEEP)
    else $error("power-save woke without global enable");
  a_adc_start: assert property (@(posedge clock) disable iff (!rst_b)
    (state == ST_ACTIVE && sleep_exec && sleep_control_reg == 4'h1 && adc_enabled)
    |=> adc_start)
    else $error("adc conversion not started");
endmodule : smcg_ctrl

// >>> smcg_ctrl_tb_top.sv
// Purpose: self-checking bench for the sleep mode and clock gating controller
// Assumes: zero wait-state register bus, start-up delay input set to 3
// Notes: wake latency is counted from the edge that raises the wake request
`timescale 1ns/1ps
module smcg_ctrl_tb_top;
  logic clock, rst_b, psel, penable, pwrite, sleep_exec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic global_irq_en, crystal_clock, adc_enabled, t2_en, t2_async;
  logic [1:0] timer2_irq_mask;
  logic [15:0] startup_cycles;
  logic [7:0] wake_req;
  smcg_pkg::smcg_wake_t wake;
  smcg_pkg::smcg_clocks_t clocks;
  smcg_pkg::smcg_periph_t periph_clk_en, periph_access_en;
  logic adc_start, comparator_en, reference_en, brownout_en, watchdog_run;
  logic input_buffer_en, test_port_en, cpu_resume, asleep;
  int error_cnt = 0;
  int compares = 0;
  int adc_cnt = 0; // conversion starts seen
  int n, a0;
  logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  int wk [5] = '{7, 6, 1, 4, 0}; // wake source bit used per mode
  logic [6:0] ex [5] = '{7'h1F, 7'h0F, 7'h00, 7'h00, 7'h04};
  smcg_ctrl smcg_ctrl_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_exec(sleep_exec), .global_irq_en(global_irq_en),
    .timer2_irq_mask(timer2_irq_mask), .startup_cycles(startup_cycles),
    .crystal_clock(crystal_clock), .debug_enable_fuse(1'b0), .test_port_enable_fuse(1'b1),
    .brownout_fuse_en(1'b1), .watchdog_en(1'b1), .adc_enabled(adc_enabled),
    .timer2_enabled(t2_en), .timer2_async(t2_async), .wake(wake), .clocks(clocks),
    .periph_clk_en(periph_clk_en), .periph_access_en(periph_access_en),
    .adc_start(adc_start), .adc_extended(), .comparator_en(comparator_en),
    .reference_en(reference_en), .brownout_en(brownout_en), .watchdog_run(watchdog_run),
    .input_buffer_en(input_buffer_en), .test_port_en(test_port_en),
    .cpu_resume(cpu_resume), .asleep(asleep));
  smcg_partner smcg_partner_i (.clock(clock), .rst_b(rst_b), .wake_req(wake_req),
    .cpu_resume(cpu_resume), .wake(wake));
  // 20 MHz system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // count conversion starts as they happen
  always @(posedge clock) begin
    if (adc_start === 1'b1) adc_cnt++;
  end
  // verdict and end of run, also reached from any expired wait
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // one comparison, counted
  task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : ck
  // one register transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      finish_test();
    end
  endtask : apb
  // program mode and enable, then pulse the sleep instruction
  task automatic go_sleep(input logic [2:0] m, input logic en);
    apb(1'b1, smcg_pkg::SLEEP_CONTROL_OFS, {28'h0, m, en});
    @(posedge clock);
    sleep_exec <= 1'b1;
    @(posedge clock);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : go_sleep
  initial begin
    {psel, penable, pwrite, sleep_exec} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wake_req = 8'h00;
    {global_irq_en, crystal_clock, adc_enabled, t2_en, t2_async} = 5'h1F;
    timer2_irq_mask = 2'h1;
    startup_cycles = 16'h0003;
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // register reset values and refusals
    apb(1'b0, smcg_pkg::SLEEP_CONTROL_OFS, 32'h0);
    ck(rd, 32'h0, "sleep ctrl reset");
    apb(1'b0, 12'h020, 32'h0);
    ck({31'h0, er}, 32'h1, "unmapped error");
    ck(rd, 32'h0, "unmapped read");
    apb(1'b1, smcg_pkg::STATUS_OFS, 32'h1);
    ck(er, 1'b1, "status write");
    $display("test registers done");
    // converter switched off before its clock is stopped
    adc_enabled <= 1'b0;
    // peripheral gating
    apb(1'b1, smcg_pkg::POWER_REDUCTION_OFS, 32'hFF);
    apb(1'b0, smcg_pkg::POWER_REDUCTION_OFS, 32'h0);
    ck(rd, 32'h0F, "gate reg readback");
    ck({periph_clk_en, periph_access_en}, 8'h00, "all gated");
    apb(1'b1, smcg_pkg::POWER_REDUCTION_OFS, 32'h05);
    #1;
    ck(periph_clk_en, 4'hA, "spi adc gated");
    apb(1'b1, smcg_pkg::POWER_REDUCTION_OFS, 32'h00);
    #1;
    ck({periph_clk_en, periph_access_en}, 8'hFF, "ungated");
    apb(1'b1, smcg_pkg::MCU_CTRL_OFS, 32'h80);
    #1;
    ck(test_port_en, 1'b0, "test port off");
    apb(1'b1, smcg_pkg::MCU_CTRL_OFS, 32'h00);
    adc_enabled <= 1'b1;
    $display("test gating done");
    // sleep refused without enable or with a reserved code
    go_sleep(3'h0, 1'b0);
    ck(asleep, 1'b0, "no enable");
    foreach (md[i]) begin
      if (i < 3) begin
        go_sleep(3'h4 + 3'(i == 2 ? 3 : i), 1'b1);
        ck(asleep, 1'b0, "reserved mode");
      end
    end
    $display("test refusals done");
    // every legal mode: entry, clocks, wake latency
    foreach (md[i]) begin
      a0 = adc_cnt;
      go_sleep(md[i], 1'b1);
      ck(asleep, 1'b1, "entered");
      ck({clocks.cpu, clocks.flash, clocks.io, clocks.adc, clocks.main_osc, input_buffer_en,
          comparator_en}, ex[i], "sleep domains");
      ck({brownout_en, watchdog_run, reference_en}, 3'h7, "monitors kept");
      ck({clocks.asy, clocks.timer_osc}, (i == 2 || i == 4) ? 2'h0 : 2'h3,
         "timer 2 clocks");
      ck(adc_cnt - a0, (i < 2) ? 1 : 0, "conversion start");
      if (i == 2) begin
        @(posedge clock);
        wake_req <= 8'h40;
        @(posedge clock);
        wake_req <= 8'h00;
        repeat (8) @(posedge clock);
        #1;
        ck(asleep, 1'b1, "foreign source");
      end
      @(posedge clock);
      wake_req <= 8'(1 << wk[i]);
      n = 0;
      do begin
        @(posedge clock);
        wake_req <= 8'h00;
        n++;
        #1;
      end while (cpu_resume !== 1'b1 && n < 200);
      if (n >= 200) begin
        error_cnt++;
        finish_test();
      end
      ck(n, ((i == 2 || i == 3) ? int'(startup_cycles) + 1 : (i == 4) ?
         smcg_pkg::STANDBY_WAKE_CYCLES : 1) + smcg_pkg::IRQ_HALT_CYCLES,
         "wake latency");
      @(posedge clock);
      #1;
      ck({asleep, clocks.cpu}, 2'h1, "resumed");
      $display("test mode %0d done", i);
    end
    finish_test();
  end
endmodule : smcg_ctrl_tb_top

// >>> smcg_partner.sv
// Purpose: behavioural model of the wake sources that surround the sleep controller
// Assumes: the bench raises a request for one cycle on the system clock
// Notes: a raised source is held until the core resumes, like a level interrupt
`timescale 1ns/1ps
module smcg_partner (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] wake_req,
  input wire logic cpu_resume,
  output smcg_pkg::smcg_wake_t wake
);
  logic [7:0] held; // sources still pending
  // hold each source until the core runs again, so a slow start-up cannot miss it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      held <= 8'h00;
    end else if (cpu_resume) begin
      held <= 8'h00;
    end else begin
      held <= held | wake_req;
    end
  end
  // request shows at once, then the held copy carries it
  assign wake = smcg_pkg::smcg_wake_t'(held | wake_req);
endmodule : smcg_partner

// >>> smcg_pkg.sv
// Purpose: constants and types for the sleep mode and clock gating controller
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes: register offsets are byte addresses, one aligned word per register
// Operation
// - mode 000 idle: stop cpu and flash clocks
// - idle: any enabled interrupt wakes
// - idle or adc-nr entry starts adc conversion
// - mode 001: stop cpu, flash, io clocks
// - adc-nr wakes only on listed sources
// - mode 010: stop oscillator and all clocks
// - power-down wakes only on listed sources
// - power-down wake waits fuse-selected start-up delay
// - mode 011 is power-down plus timer 2
// - timer 2 wake needs its mask and global enable; adc-nr wakes on timer 2 with either mask bit set
// - power-save stops unused timer 2 clock sources
// - mode 110 standby keeps oscillator, six-cycle wake
// - set gate bit stops peripheral clock, blocks access
// - cleared gate bit restarts clock, state kept
// - gate bits matter only in active and idle, adc bit also in adc-nr
// - adc stays on in sleep; restart is extended
// - comparator off in deep sleep unless reference
// - brown-out and watchdog stay active in sleep
// - input buffers off when io and adc stop
// - debug keeps main clock; test-port disable bit
// - reference on when needed by any user
// - sleep only when sleep enable bit set
// - interrupt wake halts four extra cycles
// - gate bits 3..0: timer16, spi, usart, adc
package smcg_pkg;
  // register byte offsets
  localparam logic [11:0] SLEEP_CONTROL_OFS = 12'h000;
  localparam logic [11:0] POWER_REDUCTION_OFS = 12'h004;
  localparam logic [11:0] COMPARATOR_CTRL_OFS = 12'h008;
  localparam logic [11:0] MCU_CTRL_OFS = 12'h00C;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  // field positions
  localparam int SLEEP_ENABLE_POS = 0;
  localparam int MODE_LSB_POS = 1;
  localparam int COMPARATOR_DISABLE_POS = 7;
  localparam int COMPARATOR_BANDGAP_POS = 6;
  localparam int TEST_PORT_DISABLE_POS = 7;
  // reset values
  localparam logic [3:0] SLEEP_CONTROL_RST = 4'h0;
  localparam logic [3:0] POWER_REDUCTION_RST = 4'h0;
  localparam logic [1:0] COMPARATOR_CTRL_RST = 2'h0;
  localparam logic TEST_PORT_DISABLE_RST = 1'b0;
  // mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  // timing
  localparam int CLOCK_HZ = 20000000;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int IRQ_HALT_CYCLES = 4;
  localparam int TIMER_W = 16;
  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } smcg_clocks_t;
  // per peripheral clock enables
  typedef struct packed {
    logic timer16;
    logic spi;
    logic usart;
    logic adc;
  } smcg_periph_t;
  // wake sources from the rest of the chip
  typedef struct packed {
    logic any_irq;
    logic adc_done;
    logic usi_start;
    logic timer2_ovf;
    logic timer2_cmp;
    logic store_ready;
    logic ext0_level;
    logic pin_change;
  } smcg_wake_t;
endpackage : smcg_pkg
